// ==== verilog/cdf_pkg.sv ====
/*
 * Constants, carrier types and shared helpers for the channel direction and
 * fade control block. Assumes a byte-wide register port with 8-bit offsets.
 */
package cdf_pkg;

    localparam int CH_N     = 10;
    localparam int LOW_N    = 4;
    localparam int HIGH_N   = 6;
    localparam int BREATH_N = 6;
    localparam int STRAP_W  = 2;

    localparam logic [7:0] ADDR_LOW_OUT   = 8'h03;
    localparam logic [7:0] ADDR_HIGH_DIR  = 8'h04;
    localparam logic [7:0] ADDR_LOW_DIR   = 8'h05;
    localparam logic [7:0] ADDR_HIGH_FUNC = 8'h12;
    localparam logic [7:0] ADDR_LOW_FUNC  = 8'h13;
    localparam logic [7:0] ADDR_BREATH    = 8'h14;

    localparam logic [3:0] LOW_DIR_RST   = 4'h0;
    localparam logic [5:0] HIGH_DIR_RST  = 6'h00;
    localparam logic [3:0] LOW_FUNC_RST  = 4'hF;
    localparam logic [5:0] HIGH_FUNC_RST = 6'h3F;
    localparam logic [5:0] BREATH_RST    = 6'h00;
    localparam logic [3:0] LOW_OUT_RST   = 4'h0;

    // Cycles after reset release before the strap level is trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } cdf_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cdf_req_s;

    typedef struct packed {
        cdf_state_e st;
        logic [1:0] settle;
        logic [3:0] low_out;
        logic [5:0] high_dir;
        logic [3:0] low_dir;
        logic [5:0] high_func;
        logic [3:0] low_func;
        logic [5:0] breath;
        logic [7:0] rdata;
        logic       rvalid;
        logic [9:0] pin_out;
        logic [9:0] pin_oe;
        logic [9:0] led_mode;
        logic [5:0] flash;
        logic [3:0] fade_on;
        logic [3:0] fade_off;
    } cdf_state_s;

    // LED mode (function bit 0) with breathing enabled
    function automatic logic [5:0] led_breath(input logic [5:0] func, input logic [5:0] en);
        led_breath = ~func & en;
    endfunction

    // Strap pattern for the low-group output level after reset
    function automatic logic [3:0] strap_level(input logic [1:0] ad);
        strap_level = {ad[1], ad[0], ad[1], ad[0]};
    endfunction

endpackage

// ==== verilog/cdf_pin_sync.sv ====
/*
 * Three-stage synchroniser for the address-select strap pins.
 * Assumes pins are asynchronous to sys_clk_i; output follows only once
 * the second and third stages agree.
 */
`timescale 1ns/1ps
module cdf_pin_sync (
    input  wire logic                        sys_clk_i,
    input  wire logic [cdf_pkg::STRAP_W-1:0] pin_i,
    output logic      [cdf_pkg::STRAP_W-1:0] agreed_o
);
    import cdf_pkg::*;

    typedef struct packed {
        logic [STRAP_W-1:0] meta;
        logic [STRAP_W-1:0] s2;
        logic [STRAP_W-1:0] s3;
        logic [STRAP_W-1:0] agreed;
    } cdf_sync_s;

    cdf_sync_s s_r;
    cdf_sync_s s_nxt;

    // Data path only; no reset so the strap can settle during reset
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pin_i;
        s_nxt.s2   = s_r.meta;
        s_nxt.s3   = s_r.s2;
        for (int i = 0; i < STRAP_W; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.agreed[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        s_r <= s_nxt;
    end

    assign agreed_o = s_r.agreed;

endmodule

// ==== verilog/cdf_ctrl.sv ====
/*
 * Channel direction and fade control registers for a ten-channel LED/GPIO
 * expander. Assumes the serial port engine presents decoded byte accesses
 * on req_i, and that fade timing, input sampling and the high-group output
 * level live in other blocks on the same clock.
 */
`timescale 1ns/1ps
// How it works
// - GPIO-mode low channel pin follows its output level bit.
// - Triggered-fade low channel: output bit rise starts fade-on, fall starts fade-off.
// - High direction bits 5..2 set channels 9..6 in GPIO mode: 0 output, 1 input.
// - Channel 5 in GPIO mode: high direction bit 1 picks direction.
// - Channel 4 in GPIO mode: high direction bit 0 picks direction.
// - Channels 5,4 breathing LED: direction bit picks triggered fade or flash.
// - Low channels 3..0 in GPIO mode: low direction bits pick direction.
// - Low channels breathing LED: direction bit 0 triggered fade, 1 flash.
// - All direction bits reset to zero.
// - Per-channel function bit, 0 LED, 1 GPIO, resets to one.
// - Channels 0..5 breathing enable, resets zero, gates dual meanings.
module cdf_ctrl (
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_i,
    input  wire cdf_pkg::cdf_req_s           req_i,
    input  wire logic [cdf_pkg::STRAP_W-1:0] addr_sel_pin_i,
    input  wire logic [cdf_pkg::HIGH_N-1:0]  high_level_i,
    output logic      [7:0]                  rdata_o,
    output logic                             rvalid_o,
    output logic      [cdf_pkg::CH_N-1:0]    channel_pin_o,
    output logic      [cdf_pkg::CH_N-1:0]    channel_pin_oe_o,
    output logic      [cdf_pkg::CH_N-1:0]    led_mode_o,
    output logic      [cdf_pkg::BREATH_N-1:0] periodic_flash_style_o,
    output logic      [cdf_pkg::LOW_N-1:0]   fade_on_o,
    output logic      [cdf_pkg::LOW_N-1:0]   fade_off_o
);
    import cdf_pkg::*;

    cdf_state_s           s_r;
    cdf_state_s           s_nxt;
    logic [STRAP_W-1:0]   strap;
    logic [LOW_N-1:0]     chg;
    logic [LOW_N-1:0]     fade_mask;
    logic [BREATH_N-1:0]  breath_led;
    logic [BREATH_N-1:0]  low_breath;
    logic [CH_N-1:0]      gpio;
    logic [CH_N-1:0]      dir;

    cdf_pin_sync u_strap (
        .sys_clk_i (sys_clk_i),
        .pin_i     (addr_sel_pin_i),
        .agreed_o  (strap)
    );

    always_comb begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.fade_on  = '0;
        s_nxt.fade_off = '0;
        chg        = '0;
        fade_mask  = '0;
        // Breathing LED view of the low group before this cycle's write
        low_breath = led_breath({2'h0, s_r.low_func}, s_r.breath);

        case (s_r.st)
            ST_STRAP: begin
                if (s_r.settle == STRAP_SETTLE) begin
                    s_nxt.low_out = strap_level(strap);
                    s_nxt.st      = ST_RUN;
                end else begin
                    s_nxt.settle = s_r.settle + 2'h1;
                end
            end
            ST_RUN: begin
                s_nxt.st = ST_RUN;
            end
            default: begin
                s_nxt.st = ST_STRAP;
            end
        endcase

        if (req_i.wr) begin
            case (req_i.addr)
                ADDR_LOW_OUT: begin
                    // Triggered style: LED, breathing on, direction bit low
                    fade_mask = low_breath[LOW_N-1:0] & ~s_r.low_dir;
                    chg       = req_i.wdata[LOW_N-1:0] ^ s_r.low_out;
                    s_nxt.fade_on  = chg & req_i.wdata[LOW_N-1:0] & fade_mask;
                    s_nxt.fade_off = chg & ~req_i.wdata[LOW_N-1:0] & fade_mask;
                    s_nxt.low_out  = req_i.wdata[LOW_N-1:0];
                    // Host write beats the pending strap load
                    s_nxt.st       = ST_RUN;
                end
                ADDR_HIGH_DIR:  s_nxt.high_dir  = req_i.wdata[HIGH_N-1:0];
                ADDR_LOW_DIR:   s_nxt.low_dir   = req_i.wdata[LOW_N-1:0];
                ADDR_HIGH_FUNC: s_nxt.high_func = req_i.wdata[HIGH_N-1:0];
                ADDR_LOW_FUNC:  s_nxt.low_func  = req_i.wdata[LOW_N-1:0];
                ADDR_BREATH:    s_nxt.breath    = req_i.wdata[BREATH_N-1:0];
                default: begin
                end
            endcase
        end

        if (req_i.rd) begin
            s_nxt.rvalid = 1'b1;
            case (req_i.addr)
                ADDR_LOW_OUT:   s_nxt.rdata = {4'h0, s_r.low_out};
                ADDR_HIGH_DIR:  s_nxt.rdata = {2'h0, s_r.high_dir};
                ADDR_LOW_DIR:   s_nxt.rdata = {4'h0, s_r.low_dir};
                ADDR_HIGH_FUNC: s_nxt.rdata = {2'h0, s_r.high_func};
                ADDR_LOW_FUNC:  s_nxt.rdata = {4'h0, s_r.low_func};
                ADDR_BREATH:    s_nxt.rdata = {2'h0, s_r.breath};
                default:        s_nxt.rdata = 8'h00;
            endcase
        end

        // Pin view built from the next register values so outputs stay registered
        gpio       = {s_nxt.high_func, s_nxt.low_func};
        dir        = {s_nxt.high_dir, s_nxt.low_dir};
        breath_led = led_breath({s_nxt.high_func[1:0], s_nxt.low_func}, s_nxt.breath);
        s_nxt.pin_oe   = gpio & ~dir;
        s_nxt.pin_out  = {high_level_i, s_nxt.low_out} & gpio;
        s_nxt.led_mode = ~gpio;
        s_nxt.flash    = breath_led & {s_nxt.high_dir[1:0], s_nxt.low_dir};

        if (reset_i) begin
            s_nxt           = '0;
            s_nxt.st        = ST_STRAP;
            s_nxt.low_out   = LOW_OUT_RST;
            s_nxt.high_dir  = HIGH_DIR_RST;
            s_nxt.low_dir   = LOW_DIR_RST;
            s_nxt.high_func = HIGH_FUNC_RST;
            s_nxt.low_func  = LOW_FUNC_RST;
            s_nxt.breath    = BREATH_RST;
            s_nxt.pin_oe    = {HIGH_FUNC_RST, LOW_FUNC_RST};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        s_r <= s_nxt;
    end

    assign rdata_o                = s_r.rdata;
    assign rvalid_o               = s_r.rvalid;
    assign channel_pin_o          = s_r.pin_out;
    assign channel_pin_oe_o       = s_r.pin_oe;
    assign led_mode_o             = s_r.led_mode;
    assign periodic_flash_style_o = s_r.flash;
    assign fade_on_o              = s_r.fade_on;
    assign fade_off_o             = s_r.fade_off;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence wr_to(logic [7:0] a);
        req_i.wr && req_i.addr == a;
    endsequence

    a_low_drive: assert property (
        wr_to(ADDR_LOW_OUT) ##0 (s_r.low_func == 4'hF)
        |=> channel_pin_o[3:0] == $past(req_i.wdata[3:0]))
        else $error("low group pin level does not follow written level");

    a_fade_cause: assert property (
        (|fade_on_o || |fade_off_o) |-> $past(req_i.wr) && $past(req_i.addr) == ADDR_LOW_OUT)
        else $error("fade pulse without an output level write");

    a_fade_edge: assert property (
        wr_to(ADDR_LOW_OUT) ##0 (s_r.low_func[0] == 1'b0 && s_r.breath[0] && !s_r.low_dir[0]
        && !s_r.low_out[0] && req_i.wdata[0])
        |=> fade_on_o[0] && !fade_off_o[0] ##1 !fade_on_o[0])
        else $error("rising level in triggered style gave no single fade-on pulse");

    a_high_dir_oe: assert property (
        wr_to(ADDR_HIGH_DIR) ##0 !req_i.rd
        |=> channel_pin_oe_o[9:6] == (~$past(req_i.wdata[5:2]) & s_r.high_func[5:2]))
        else $error("channels 9..6 direction wrong after write");

    a_ch5_dir: assert property (
        s_r.high_func[1] |-> channel_pin_oe_o[5] == !s_r.high_dir[1])
        else $error("channel 5 direction wrong");

    a_ch4_dir: assert property (
        s_r.high_func[0] |-> channel_pin_oe_o[4] == !s_r.high_dir[0])
        else $error("channel 4 direction wrong");

    a_high_flash: assert property (
        periodic_flash_style_o[5:4] != 2'h0 |-> led_mode_o[5:4] != 2'h0
        && s_r.breath[5:4] != 2'h0 && !channel_pin_oe_o[5] | !channel_pin_oe_o[4])
        else $error("flash style on channel 5 or 4 without breathing LED mode");

    a_low_flash: assert property (
        wr_to(ADDR_LOW_DIR) ##0 (s_r.low_func == 4'h0) ##0 (s_r.breath[3:0] == 4'hF)
        |=> periodic_flash_style_o[3:0] == $past(req_i.wdata[3:0]))
        else $error("low group flash style does not follow direction bits");

    a_dir_reset: assert property (
        $past(reset_i) |-> channel_pin_oe_o == 10'h3FF && periodic_flash_style_o == 6'h00
        && led_mode_o == 10'h000)
        else $error("direction, function or breathing reset values wrong");

    a_upper_zero: assert property (
        rvalid_o && ($past(req_i.addr) == ADDR_LOW_OUT || $past(req_i.addr) == ADDR_LOW_DIR)
        |-> rdata_o[7:4] == 4'h0)
        else $error("unused upper bits read non-zero");

    a_low_dir_oe: assert property (
        wr_to(ADDR_LOW_DIR) ##0 (s_r.low_func == 4'hF)
        |=> channel_pin_oe_o[3:0] == ~$past(req_i.wdata[3:0]))
        else $error("low group direction does not follow written bits");

    a_gpio_no_fade: assert property (
        wr_to(ADDR_LOW_OUT) ##0 (s_r.low_func == 4'hF)
        |=> fade_on_o == 4'h0 && fade_off_o == 4'h0)
        else $error("fade pulse on a low channel in GPIO mode");

    a_fade_fall: assert property (
        wr_to(ADDR_LOW_OUT) ##0 (s_r.low_func[2] == 1'b0 && s_r.breath[2] && !s_r.low_dir[2]
        && s_r.low_out[2] && !req_i.wdata[2])
        |=> fade_off_o[2] && !fade_on_o[2])
        else $error("falling level in triggered style gave no fade-off pulse");

    a_breath_gate: assert property (
        wr_to(ADDR_BREATH)
        |=> (periodic_flash_style_o & ~$past(req_i.wdata[5:0])) == 6'h00)
        else $error("flash style on a channel without breathing enabled");

    a_read_answer: assert property (
        req_i.rd |=> rvalid_o)
        else $error("read gave no answer one cycle later");

endmodule

// ==== tb/cdf_host_model.sv ====
/*
 * Host-side model that issues byte accesses on the register port.
 * Assumes the block answers reads on the same edge that takes the request.
 */
`timescale 1ns/1ps
module cdf_host_model (
    input  wire logic         sys_clk_i,
    input  wire logic [7:0]   rdata_i,
    input  wire logic         rvalid_i,
    output cdf_pkg::cdf_req_s req_o
);
    import cdf_pkg::*;
    initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    // Released fields show the inverse so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        #1;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the channel direction and fade control block.
 * Assumes the host model drives the register port and straps change only while reset is held.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import cdf_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [1:0] addr_sel_pin_i = 2'b10;
    logic [5:0] high_level_i = 6'h00;
    cdf_req_s   req;
    logic [7:0] rdata;
    logic       rvalid;
    logic [9:0] pin, oe, led;
    logic [5:0] flash;
    logic [3:0] f_on, f_off;
    int         error_cnt = 0;
    int         total_checks = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    cdf_ctrl cdf_ctrl_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
        .addr_sel_pin_i(addr_sel_pin_i), .high_level_i(high_level_i), .rdata_o(rdata),
        .rvalid_o(rvalid), .channel_pin_o(pin), .channel_pin_oe_o(oe), .led_mode_o(led),
        .periodic_flash_style_o(flash), .fade_on_o(f_on), .fade_off_o(f_off));
    cdf_host_model cdf_host_model_inst (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .req_o(req));
    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cdf_host_model_inst.write_reg(a, d);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        cdf_host_model_inst.read_reg(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask
    task automatic t_defaults();
        logic [7:0] adr [6] = '{8'h04, 8'h05, 8'h12, 8'h13, 8'h14, 8'h20};
        logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h3F, 8'h0F, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd_chk(adr[i], exp[i]);
        end
        `CHK("oe", 10'h3FF, oe)
        `CHK("led", 10'h000, led)
    endtask
    task automatic t_strap();
        rd_chk(8'h03, 8'h0A);
        `CHK("pin_lo", 4'hA, pin[3:0])
    endtask
    task automatic t_gpio();
        wr(8'h03, 8'hF5);
        `CHK("pin_lo", 4'h5, pin[3:0])
        rd_chk(8'h03, 8'h05);
        wr(8'h05, 8'hFA);
        `CHK("oe_lo", 4'h5, oe[3:0])
        wr(8'h04, 8'hFF);
        `CHK("oe_hi", 6'h00, oe[9:4])
        rd_chk(8'h04, 8'h3F);
        wr(8'h04, 8'h15);
        `CHK("oe_hi", 6'h2A, oe[9:4])
        @(posedge sys_clk_i);
        high_level_i <= 6'h2D;
        @(posedge sys_clk_i);
        #1;
        `CHK("pin_hi", 6'h2D, pin[9:4])
        wr(8'h05, 8'h00);
        wr(8'h04, 8'h00);
    endtask
    task automatic t_fade();
        wr(8'h03, 8'h00);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'h3F);
        `CHK("led", 10'h00F, led)
        `CHK("oe_lo", 4'h0, oe[3:0])
        `CHK("pin_lo", 4'h0, pin[3:0])
        wr(8'h03, 8'h05);
        `CHK("fade_on", 4'h5, f_on)
        `CHK("fade_off", 4'h0, f_off)
        @(posedge sys_clk_i);
        #1;
        `CHK("fade_on", 4'h0, f_on)
        wr(8'h03, 8'h04);
        `CHK("fade_off", 4'h1, f_off)
        `CHK("fade_on", 4'h0, f_on)
        wr(8'h05, 8'h03);
        `CHK("flash", 6'h03, flash)
        wr(8'h03, 8'h00);
        `CHK("fade_off", 4'h4, f_off)
        wr(8'h14, 8'h3E);
        `CHK("flash", 6'h02, flash)
    endtask
    task automatic t_high();
        wr(8'h13, 8'h0F);
        wr(8'h05, 8'h01);
        wr(8'h14, 8'h3F);
        wr(8'h12, 8'h00);
        wr(8'h04, 8'h03);
        `CHK("flash", 6'h30, flash)
        `CHK("oe", 10'h00E, oe)
        `CHK("led", 10'h3F0, led)
        wr(8'h12, 8'h3F);
        `CHK("flash", 6'h00, flash)
        `CHK("oe", 10'h3CE, oe)
    endtask
    task automatic t_rerun();
        @(posedge sys_clk_i);
        addr_sel_pin_i <= 2'h1;
        reset_i        <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK("oe_rst", 10'h3FF, oe)
        `CHK("led_rst", 10'h000, led)
        `CHK("flash_rst", 6'h00, flash)
        repeat (6) @(posedge sys_clk_i);
        rd_chk(8'h03, 8'h05);
        `CHK("pin_lo", 4'h5, pin[3:0])
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h04, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK("oe_rst", 10'h3FF, oe)
        `CHK("rvalid_rst", 1'b0, rvalid)
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        t_strap();
        t_defaults();
        t_gpio();
        t_fade();
        t_high();
        t_rerun();
        summarize();
    end
    // Whole run needs about a hundred cycles; generous margin
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        error_cnt++;
        summarize();
    end
endmodule
